//--- ucs_pkg.sv
// Shared constants for the serial port control and status block
package ucs_pkg;

    // Register addresses
    localparam logic [7:0] CTL_ADDR = 8'h98;
    localparam logic [7:0] BUF_ADDR = 8'h99;

    // Bit positions inside serial_port_control_status
    localparam int OVR_BIT = 7;
    localparam int PERR_BIT = 6;
    localparam int THRE_BIT = 5;
    localparam int REN_BIT = 4;
    localparam int TBX_BIT = 3;
    localparam int RBX_BIT = 2;
    localparam int TI_BIT = 1;
    localparam int RI_BIT = 0;

    // Reset value of the control and status register
    localparam logic [7:0] CTL_RESET = 8'h20;

    // Parity type encodings
    localparam logic [1:0] PAR_ODD = 2'h0;
    localparam logic [1:0] PAR_EVEN = 2'h1;
    localparam logic [1:0] PAR_MARK = 2'h2;
    localparam logic [1:0] PAR_SPACE = 2'h3;

    // Receive queue geometry: data byte plus extra bit
    localparam int RXQ_WIDTH = 9;
    localparam int RXQ_DEPTH = 2;
    localparam logic [1:0] RXQ_FULL = 2'h2;

endpackage : ucs_pkg

//--- ucs_rxq_if.sv
// Handshake bundle between the register block and its receive queue
`timescale 1ns/1ps
interface ucs_rxq_if;
    logic in_valid;
    logic in_ready;
    logic [ucs_pkg::RXQ_WIDTH-1:0] in_data;
    logic out_valid;
    logic out_ready;
    logic [ucs_pkg::RXQ_WIDTH-1:0] out_data;

    modport ctrl (
        output in_valid,
        output in_data,
        output out_ready,
        input in_ready,
        input out_valid,
        input out_data
    );

    modport queue (
        input in_valid,
        input in_data,
        input out_ready,
        output in_ready,
        output out_valid,
        output out_data
    );
endinterface : ucs_rxq_if

//--- ucs_rx_queue.sv
// Two-entry receive queue with valid and ready on both sides
`timescale 1ns/1ps
module ucs_rx_queue (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    input wire logic ce_i,
    // Queue ports
    ucs_rxq_if.queue q
);

    typedef struct packed {
        logic [ucs_pkg::RXQ_DEPTH-1:0][ucs_pkg::RXQ_WIDTH-1:0] mem;
        logic wr_ptr;
        logic rd_ptr;
        logic [1:0] count;
    } ucs_rxq_state_type;

    ucs_rxq_state_type st_ff;
    ucs_rxq_state_type nxt_st;
    logic push;
    logic pop;

    assign q.in_ready = (st_ff.count != ucs_pkg::RXQ_FULL);
    assign q.out_valid = (st_ff.count != 2'h0);
    assign q.out_data = st_ff.mem[st_ff.rd_ptr];

    always_comb
    begin
        nxt_st = st_ff;
        push = q.in_valid && q.in_ready;
        pop = q.out_valid && q.out_ready;
        if (push)
        begin
            nxt_st.mem[st_ff.wr_ptr] = q.in_data;
            nxt_st.wr_ptr = ~st_ff.wr_ptr;
        end
        if (pop)
        begin
            nxt_st.rd_ptr = ~st_ff.rd_ptr;
        end
        case ({push, pop})
            2'b10: nxt_st.count = st_ff.count + 2'h1;
            2'b01: nxt_st.count = st_ff.count - 2'h1;
            default: nxt_st.count = st_ff.count;
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            st_ff <= '0;
        else if (ce_i)
            st_ff <= nxt_st;
    end

endmodule : ucs_rx_queue

//--- ucs_ctrl_status.sv
// Serial port control and status register with transmit holding and receive buffer
`timescale 1ns/1ps
module ucs_ctrl_status (
    // Clock, reset, clock enable
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    input wire logic ce_i,
    // Special-function register port
    input wire logic [7:0] sfr_addr_i,
    input wire logic sfr_wr_i,
    input wire logic sfr_bit_wr_i,
    input wire logic [2:0] sfr_bit_sel_i,
    input wire logic sfr_bit_val_i,
    input wire logic [7:0] sfr_wdata_i,
    input wire logic sfr_rd_i,
    output logic [7:0] sfr_rdata_o,
    // Frame format from the mode register
    input wire logic parity_enable_i,
    input wire logic [1:0] parity_type_i,
    input wire logic extra_bit_enable_i,
    input wire logic mce_i,
    // Transmit shifter
    output logic tx_valid_o,
    output logic [7:0] tx_data_o,
    output logic tx_extra_o,
    input wire logic tx_ready_i,
    input wire logic tx_stop_start_i,
    // Receive shifter
    output logic rx_enable_o,
    input wire logic rx_byte_valid_i,
    input wire logic [7:0] rx_data_i,
    input wire logic rx_xbit_i,
    input wire logic rx_stop_ok_i
);

    typedef struct packed {
        logic ovr;
        logic perr;
        logic ren;
        logic tbx;
        logic rbx;
        logic ti;
        logic ri;
        logic hold_valid;
        logic [7:0] hold_data;
        logic tx_extra;
        logic head_valid;
        logic [7:0] head_data;
        logic [7:0] rdata;
    } ucs_ctl_state_type;

    ucs_ctl_state_type st_ff;
    ucs_ctl_state_type nxt_st;
    ucs_rxq_if q ();

    logic ctl_wr;
    logic buf_wr;
    logic buf_rd;
    logic pop;
    logic [7:0] ctl_cur;
    logic [7:0] ctl_new;

    // Parity bit that a byte must carry for the selected type
    function automatic logic par_bit(input logic [7:0] d, input logic [1:0] pt);
        case (pt)
            ucs_pkg::PAR_ODD: par_bit = ~^d;
            ucs_pkg::PAR_EVEN: par_bit = ^d;
            ucs_pkg::PAR_MARK: par_bit = 1'b1;
            default: par_bit = 1'b0;
        endcase
    endfunction : par_bit

    // Byte write replaces all bits, bit write replaces one
    function automatic logic [7:0] merge_wr(input logic [7:0] cur, input logic byte_wr,
                                            input logic [7:0] wd, input logic [2:0] sel,
                                            input logic val);
        merge_wr = cur;
        if (byte_wr)
            merge_wr = wd;
        else
            merge_wr[sel] = val;
    endfunction : merge_wr

    ucs_rx_queue u_rxq (
        .ref_clk_i(ref_clk_i),
        .rstn_i(rstn_i),
        .ce_i(ce_i),
        .q(q.queue)
    );

    assign ctl_wr = (sfr_wr_i || sfr_bit_wr_i) && (sfr_addr_i == ucs_pkg::CTL_ADDR);
    assign buf_wr = sfr_wr_i && (sfr_addr_i == ucs_pkg::BUF_ADDR);
    assign buf_rd = sfr_rd_i && (sfr_addr_i == ucs_pkg::BUF_ADDR);
    assign ctl_cur = {st_ff.ovr, st_ff.perr, ~st_ff.hold_valid, st_ff.ren,
                      st_ff.tbx, st_ff.rbx, st_ff.ti, st_ff.ri};
    assign ctl_new = merge_wr(ctl_cur, sfr_wr_i, sfr_wdata_i, sfr_bit_sel_i, sfr_bit_val_i);

    // Stopped receiver pushes nothing; the queue keeps draining
    assign q.in_valid = rx_byte_valid_i && st_ff.ren && rx_stop_ok_i;
    assign q.in_data = {rx_xbit_i, rx_data_i};
    assign q.out_ready = !st_ff.head_valid || buf_rd;
    assign pop = q.out_valid && q.out_ready;

    always_comb
    begin
        nxt_st = st_ff;
        // Software writes first so that hardware events below win
        if (ctl_wr)
        begin
            nxt_st.ovr = ctl_new[ucs_pkg::OVR_BIT];
            nxt_st.perr = ctl_new[ucs_pkg::PERR_BIT];
            nxt_st.ren = ctl_new[ucs_pkg::REN_BIT];
            nxt_st.tbx = ctl_new[ucs_pkg::TBX_BIT];
            nxt_st.rbx = ctl_new[ucs_pkg::RBX_BIT];
            nxt_st.ti = ctl_new[ucs_pkg::TI_BIT];
            nxt_st.ri = ctl_new[ucs_pkg::RI_BIT] || (st_ff.ri && q.out_valid);
        end
        // Holding register; THRE is its inverse and has no storage of its own
        if (st_ff.hold_valid && tx_ready_i)
            nxt_st.hold_valid = 1'b0;
        if (buf_wr)
        begin
            nxt_st.hold_valid = 1'b1;
            nxt_st.hold_data = sfr_wdata_i;
        end
        if (tx_stop_start_i)
            nxt_st.ti = 1'b1;
        if (rx_byte_valid_i && st_ff.ren && rx_stop_ok_i)
        begin
            if (!q.in_ready)
                nxt_st.ovr = 1'b1;
            else if (!mce_i || rx_xbit_i)
                nxt_st.ri = 1'b1;
        end
        // Head of the receive buffer is the byte software reads
        if (buf_rd)
            nxt_st.head_valid = 1'b0;
        if (pop)
        begin
            nxt_st.head_valid = 1'b1;
            nxt_st.head_data = q.out_data[7:0];
            nxt_st.rbx = q.out_data[8];
            if (parity_enable_i && (q.out_data[8] != par_bit(q.out_data[7:0], parity_type_i)))
                nxt_st.perr = 1'b1;
        end
        // Extra bit is parity when parity is enabled, else the register when the extra bit is enabled, else zero
        if (parity_enable_i)
            nxt_st.tx_extra = par_bit(nxt_st.hold_data, parity_type_i);
        else if (extra_bit_enable_i)
            nxt_st.tx_extra = nxt_st.tbx;
        else
            nxt_st.tx_extra = 1'b0;
        if (sfr_rd_i && (sfr_addr_i == ucs_pkg::CTL_ADDR))
            nxt_st.rdata = ctl_cur;
        else if (buf_rd)
            nxt_st.rdata = st_ff.head_data;
        else if (sfr_rd_i)
            nxt_st.rdata = 8'h00;
    end

    always_ff @(posedge ref_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            st_ff <= '0;
        else if (ce_i)
            st_ff <= nxt_st;
    end

    assign sfr_rdata_o = st_ff.rdata;
    assign tx_valid_o = st_ff.hold_valid;
    assign tx_data_o = st_ff.hold_data;
    assign tx_extra_o = st_ff.tx_extra;
    assign rx_enable_o = st_ff.ren;

    // Checks
    sequence s_drop;
        ce_i && rx_byte_valid_i && st_ff.ren && rx_stop_ok_i && !q.in_ready;
    endsequence

    sequence s_pop_bad;
        ce_i && pop && parity_enable_i
            && (q.out_data[8] != par_bit(q.out_data[7:0], parity_type_i));
    endsequence

    sequence s_ren_bitwr;
        ce_i && sfr_bit_wr_i && !sfr_wr_i && (sfr_addr_i == ucs_pkg::CTL_ADDR)
            && (sfr_bit_sel_i == 3'(ucs_pkg::REN_BIT));
    endsequence

    AST_OVR_SET: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        s_drop |=> st_ff.ovr)
        else $error("overrun flag not set after dropped byte");

    AST_PERR_SET: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        s_pop_bad |=> st_ff.perr && st_ff.head_valid)
        else $error("parity error flag not set on bad byte");

    AST_PERR_STICKY: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        st_ff.perr && !(ce_i && ctl_wr) |=> st_ff.perr)
        else $error("parity error flag cleared by hardware");

    AST_THRE_READ: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        ce_i && sfr_rd_i && (sfr_addr_i == ucs_pkg::CTL_ADDR)
            |=> sfr_rdata_o[ucs_pkg::THRE_BIT] == !$past(st_ff.hold_valid))
        else $error("holding empty flag misreported");

    AST_THRE_NO_WR: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        $rose(st_ff.hold_valid) |-> $past(ce_i && buf_wr))
        else $error("holding register filled without buffer write");

    AST_REN_BIT: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        s_ren_bitwr |=> st_ff.ren == $past(sfr_bit_val_i))
        else $error("bit write to receive enable not taken");

    AST_REN_OFF: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        ce_i && rx_byte_valid_i && !st_ff.ren && !ctl_wr |=> st_ff.ovr == $past(st_ff.ovr))
        else $error("byte taken while receiver off");

    AST_READ_OFF: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        ce_i && buf_rd && !st_ff.ren ##1 1'b1 |-> sfr_rdata_o == $past(st_ff.head_data))
        else $error("buffer read blocked while receiver off");

    AST_TI_SET: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        ce_i && tx_stop_start_i |=> st_ff.ti)
        else $error("transmit done not set at stop bit");

    AST_RI_HOLD: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        ce_i && st_ff.ri && q.out_valid |=> st_ff.ri)
        else $error("receive ready cleared with bytes queued");

    AST_EXTRA: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        ce_i && extra_bit_enable_i && !parity_enable_i |=> tx_extra_o == st_ff.tbx)
        else $error("extra bit does not follow register");

endmodule : ucs_ctrl_status

//--- ucs_far_model.sv
// Behavioural remote transceiver standing beyond the shift registers
`timescale 1ns/1ps
module ucs_far_model (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    // Transmit shifter side
    input wire logic tx_valid_i,
    input wire logic [7:0] tx_data_i,
    output logic tx_ready_o,
    output logic tx_stop_o,
    output logic [7:0] tx_seen_o,
    // Receive shifter side
    output logic rx_valid_o,
    output logic [7:0] rx_data_o,
    output logic rx_xbit_o,
    output logic rx_stop_ok_o
);
    int stall = 0;
    initial
    begin
        tx_ready_o = 1'b0;
        tx_stop_o = 1'b0;
        tx_seen_o = 8'h00;
        rx_valid_o = 1'b0;
        rx_data_o = 8'h00;
        rx_xbit_o = 1'b0;
        rx_stop_ok_o = 1'b0;
        forever
        begin
            @(negedge ref_clk_i);
            if (rstn_i && tx_valid_i)
            begin
                repeat (stall) @(negedge ref_clk_i);
                tx_ready_o = 1'b1;
                tx_seen_o = tx_data_i;
                @(negedge ref_clk_i);
                tx_ready_o = 1'b0;
                // Short frame: shift time before the stop bit
                repeat (10) @(negedge ref_clk_i);
                tx_stop_o = 1'b1;
                @(negedge ref_clk_i);
                tx_stop_o = 1'b0;
            end
        end
    end
    task automatic send_byte(input logic [7:0] d, input logic x, input logic ok);
        @(negedge ref_clk_i);
        rx_valid_o = 1'b1;
        rx_data_o = d;
        rx_xbit_o = x;
        rx_stop_ok_o = ok;
        @(negedge ref_clk_i);
        rx_valid_o = 1'b0;
        // Released lines must not keep the old value
        rx_data_o = ~d;
        rx_xbit_o = ~x;
        rx_stop_ok_o = ~ok;
    endtask : send_byte
endmodule : ucs_far_model

//--- tb_uart_control_status_reg.sv
// Self-checking bench for the serial port control and status block
`timescale 1ns/1ps
module tb_uart_control_status_reg;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [7:0] addr = 8'h00;
    logic wr = 1'b0;
    logic bwr = 1'b0;
    logic [2:0] bsel = 3'h0;
    logic bval = 1'b0;
    logic [7:0] wdata = 8'h00;
    logic rd = 1'b0;
    logic [7:0] rdata;
    logic pen = 1'b0;
    logic [1:0] ptype = 2'h0;
    logic xbe = 1'b0;
    logic mce = 1'b0;
    logic txv, txx, txr, txs, rxen, rxv, rxx, rxok;
    logic [7:0] txd, txseen, rxd;
    int err_count = 0;
    int compares = 0;
    localparam logic [7:0] CA = ucs_pkg::CTL_ADDR;
    localparam logic [7:0] BA = ucs_pkg::BUF_ADDR;

    ucs_ctrl_status dut_u (.ref_clk_i(clk), .rstn_i(rstn), .ce_i(1'b1), .sfr_addr_i(addr),
        .sfr_wr_i(wr), .sfr_bit_wr_i(bwr), .sfr_bit_sel_i(bsel), .sfr_bit_val_i(bval),
        .sfr_wdata_i(wdata), .sfr_rd_i(rd), .sfr_rdata_o(rdata), .parity_enable_i(pen),
        .parity_type_i(ptype), .extra_bit_enable_i(xbe), .mce_i(mce), .tx_valid_o(txv),
        .tx_data_o(txd), .tx_extra_o(txx), .tx_ready_i(txr), .tx_stop_start_i(txs),
        .rx_enable_o(rxen), .rx_byte_valid_i(rxv), .rx_data_i(rxd), .rx_xbit_i(rxx),
        .rx_stop_ok_i(rxok));
    ucs_far_model far_u (.ref_clk_i(clk), .rstn_i(rstn), .tx_valid_i(txv), .tx_data_i(txd),
        .tx_ready_o(txr), .tx_stop_o(txs), .tx_seen_o(txseen), .rx_valid_o(rxv),
        .rx_data_o(rxd), .rx_xbit_o(rxx), .rx_stop_ok_o(rxok));

    initial
    begin
        forever #10 clk = ~clk;
    end

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp)
        begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // Read data is registered, so sample one and a half cycles after the read edge
    task automatic rchk(input string w, input logic [7:0] a, input logic [7:0] m,
                        input logic [7:0] exp);
        @(negedge clk);
        addr = a;
        rd = 1'b1;
        @(negedge clk);
        rd = 1'b0;
        @(negedge clk);
        chk(w, exp, rdata & m);
    endtask : rchk

    task automatic wrb(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge clk);
        wr = 1'b0;
    endtask : wrb

    task automatic bw(input int s, input logic v);
        @(negedge clk);
        addr = CA;
        bsel = 3'(s);
        bval = v;
        bwr = 1'b1;
        @(negedge clk);
        bwr = 1'b0;
    endtask : bw

    task automatic t_reset;
        rchk("ctl reset", CA, 8'hff, ucs_pkg::CTL_RESET);
        rchk("unmapped", 8'h55, 8'hff, 8'h00);
        wrb(CA, 8'h00);
        rchk("ctl after byte write", CA, 8'hff, 8'h20);
        bw(ucs_pkg::REN_BIT, 1'b1);
        rchk("ctl after bit write", CA, 8'hff, 8'h30);
        chk("rx enable", 8'h01, {7'h0, rxen});
        bw(ucs_pkg::THRE_BIT, 1'b0);
        rchk("holding empty kept", CA, 8'hff, 8'h30);
        $display("test reset done");
    endtask : t_reset

    task automatic t_tx;
        far_u.stall = 3;
        bw(ucs_pkg::TBX_BIT, 1'b1);
        chk("tx extra off", 8'h00, {7'h0, txx});
        xbe = 1'b1;
        @(negedge clk);
        chk("tx extra", 8'h01, {7'h0, txx});
        rchk("ctl before write", CA, 8'hff, 8'h38);
        wrb(BA, 8'hc3);
        chk("tx valid", 8'h01, {7'h0, txv});
        rchk("holding full", CA, 8'hff, 8'h18);
        // Stop pulse is driven on a falling edge, so look for it on the rising one
        for (int i = 0; i < 60 && txs !== 1'b1; i++) @(posedge clk);
        chk("stop seen", 8'h01, {7'h0, txs});
        chk("byte sent", 8'hc3, txseen);
        repeat (2) @(negedge clk);
        rchk("tx done", CA, 8'hff, 8'h3a);
        repeat (5) @(negedge clk);
        rchk("tx done sticky", CA, 8'hff, 8'h3a);
        bw(ucs_pkg::TI_BIT, 1'b0);
        bw(ucs_pkg::TBX_BIT, 1'b0);
        rchk("ctl cleared", CA, 8'hff, 8'h30);
        $display("test transmit done");
    endtask : t_tx

    task automatic t_rx;
        far_u.send_byte(8'h3c, 1'b1, 1'b1);
        repeat (3) @(negedge clk);
        rchk("rx ready and extra", CA, 8'hff, 8'h35);
        rchk("rx byte", BA, 8'hff, 8'h3c);
        bw(ucs_pkg::RI_BIT, 1'b0);
        far_u.send_byte(8'h0f, 1'b0, 1'b0);
        far_u.send_byte(8'h11, 1'b0, 1'b1);
        far_u.send_byte(8'h22, 1'b0, 1'b1);
        far_u.send_byte(8'h33, 1'b0, 1'b1);
        far_u.send_byte(8'h44, 1'b0, 1'b1);
        repeat (3) @(negedge clk);
        rchk("overrun", CA, 8'h81, 8'h81);
        bw(ucs_pkg::RI_BIT, 1'b0);
        rchk("rx ready held", CA, 8'h01, 8'h01);
        bw(ucs_pkg::REN_BIT, 1'b0);
        chk("rx disabled", 8'h00, {7'h0, rxen});
        bw(ucs_pkg::OVR_BIT, 1'b0);
        far_u.send_byte(8'h55, 1'b0, 1'b1);
        rchk("no overrun while off", CA, 8'h80, 8'h00);
        rchk("held byte 1", BA, 8'hff, 8'h11);
        rchk("held byte 2", BA, 8'hff, 8'h22);
        rchk("held byte 3", BA, 8'hff, 8'h33);
        bw(ucs_pkg::RI_BIT, 1'b0);
        bw(ucs_pkg::OVR_BIT, 1'b0);
        rchk("flags clear", CA, 8'h81, 8'h00);
        $display("test receive done");
    endtask : t_rx

    task automatic t_parity;
        logic [3:0] good;
        good = 4'b0110;
        bw(ucs_pkg::REN_BIT, 1'b1);
        xbe = 1'b0;
        pen = 1'b1;
        for (int t = 0; t < 4; t++)
        begin
            ptype = 2'(t);
            far_u.send_byte(8'h01, good[t], 1'b1);
            far_u.send_byte(8'h01, ~good[t], 1'b1);
            repeat (3) @(negedge clk);
            rchk("parity good", CA, 8'h40, 8'h00);
            rchk("pop", BA, 8'hff, 8'h01);
            repeat (3) @(negedge clk);
            rchk("parity bad", CA, 8'h40, 8'h40);
            rchk("pop", BA, 8'hff, 8'h01);
            repeat (5) @(negedge clk);
            rchk("parity sticky", CA, 8'h40, 8'h40);
            bw(ucs_pkg::PERR_BIT, 1'b0);
            bw(ucs_pkg::RI_BIT, 1'b0);
            rchk("parity cleared", CA, 8'h41, 8'h00);
        end
        // Address filtering: only bytes with the extra bit raise receive ready
        pen = 1'b0;
        mce = 1'b1;
        far_u.send_byte(8'h5a, 1'b0, 1'b1);
        repeat (3) @(negedge clk);
        rchk("address filter", CA, 8'h01, 8'h00);
        rchk("filtered byte", BA, 8'hff, 8'h5a);
        far_u.send_byte(8'ha5, 1'b1, 1'b1);
        repeat (3) @(negedge clk);
        rchk("address byte", CA, 8'h05, 8'h05);
        rchk("address data", BA, 8'hff, 8'ha5);
        mce = 1'b0;
        bw(ucs_pkg::RI_BIT, 1'b0);
        $display("test parity done");
    endtask : t_parity

    task automatic report_and_stop;
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : report_and_stop

    initial
    begin
        repeat (6) @(negedge clk);
        rstn = 1'b1;
        t_reset();
        t_tx();
        t_rx();
        t_parity();
        report_and_stop();
    end

    // Whole run is under a thousand cycles; allow ample margin
    initial
    begin
        repeat (20000) @(posedge clk);
        err_count++;
        report_and_stop();
    end
endmodule : tb_uart_control_status_reg
